// ---- inc/acs_pkg.sv ----
// Constants, field layouts and state encodings of the conversion sequencer
package acs_pkg;
  // Slot count and slot index width
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h7;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 3'h0;
  // Slots with a fixed purpose in the device
  localparam logic [SLOT_W-1:0] CURRENT_SLOT = 3'h0;
  localparam logic [SLOT_W-1:0] ZERO_ERROR_SLOT = 3'h6;

  // Slot control word layout
  localparam int CTRL_W = 8;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_RES_HI = 6;
  localparam int CTRL_RES_LO = 4;
  localparam int CTRL_REF_BIT = 3;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_SEL_LO = 0;

  // Input select codes of the analog mux
  localparam logic [2:0] SEL_CURRENT = 3'h0;
  localparam logic [2:0] SEL_INT_TEMP = 3'h1;
  localparam logic [2:0] SEL_THERMISTOR = 3'h2;
  localparam logic [2:0] SEL_PACK = 3'h3;
  localparam logic [2:0] SEL_UPPER_CELL = 3'h4;
  localparam logic [2:0] SEL_LOWER_CELL = 3'h5;
  localparam logic [2:0] SEL_ZERO_ERROR = 3'h6;

  // Reference range bit values
  localparam logic REF_170MV = 1'b0;
  localparam logic REF_340MV = 1'b1;

  // Resolution: code 0 is 9 bits, code 7 is 16 bits, sign included
  localparam int RES_BITS_W = 5;
  localparam logic [RES_BITS_W-1:0] RES_BASE_BITS = 5'h09;

  // Result word layout, sign and magnitude
  localparam int RESULT_W = 16;
  localparam int SIGN_BIT = 15;
  localparam int MAG_W = 15;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  // Clock and time base
  localparam longint CLK_HZ = 125_000_000;
  localparam longint TICK_HZ = 131_072;
  localparam int TICK_CYCLES_DEF = int'(CLK_HZ / TICK_HZ);
  localparam int TICK_W = 16;

  // Conversion time unit, multiplied by two to the resolution
  localparam longint CONV_UNIT_NS = 30_520;
  // Rounded to the nearest tick: the printed unit is itself a rounded
  // multiple of the tick, so rounding up would add a whole tick per unit
  localparam longint UNIT_TICKS =
    (CONV_UNIT_NS * TICK_HZ + 64'h0000_0000_1DCD_6500) /
    64'h0000_0000_3B9A_CA00;
  localparam int CONV_CNT_W = 20;

  // Accumulation period
  localparam longint ACC_PERIOD_MS = 500;
  localparam int ACC_TICKS_DEF = int'(TICK_HZ * ACC_PERIOD_MS / 1000);
  localparam int ACC_CNT_W = 18;
  localparam int ACC_W = 32;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;

  // Sequencer states, Gray coded along idle, setup, convert
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SETUP = 2'b01,
    ACS_CONV = 2'b11
  } acs_state_t;
endpackage

// ---- logic/acs_sequencer.sv ----
// Eight-slot conversion sequencer with result store and charge accumulation
//
// Notes on behaviour
// - Repeat one-to-eight-conversion cycles while enabled.
// - Visit slot controls in order, run each.
// - Enabled slot converts; disabled slot is skipped.
// - Result lands in the same slot's register.
// - Three-bit select routes one of seven sources.
// - Enable 7, resolution 6-4, range 3, select 2-0.
// - Resolution code gives 9 to 16 bits.
// - Conversion lasts 30.52 us times two-to-n.
// - Range bit zero 170 mV, one 340 mV.
// - Results sign-magnitude, sign in bit 15.
// - Select code zero routes sense input.
// - Zero-error source shorts converter input internally.
// - Slot purposes fixed; slot six forced short.
// - Accumulators and timers use slot zero only.
// - Accumulate every 500 ms when enabled.
// - Positive sign to charge, negative to discharge.
// - All timing from 131072 Hz time base.
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int ACC_TICKS = ACC_TICKS_DEF
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic adc_enable_i,
  input wire logic accum_enable_i,
  input wire logic [CTRL_W-1:0] current_slot_control_i,
  input wire logic [CTRL_W-1:0] internal_temp_slot_control_i,
  input wire logic [CTRL_W-1:0] external_temp_slot_control_i,
  input wire logic [CTRL_W-1:0] pack_voltage_slot_control_i,
  input wire logic [CTRL_W-1:0] upper_cell_slot_control_i,
  input wire logic [CTRL_W-1:0] lower_cell_slot_control_i,
  input wire logic [CTRL_W-1:0] zero_error_slot_control_i,
  input wire logic [CTRL_W-1:0] spare_slot_control_i,
  input wire logic adc_sign_i,
  input wire logic [MAG_W-1:0] adc_mag_i,
  output logic [2:0] mux_sel_o,
  output logic mux_short_o,
  output logic ref_range_o,
  output logic [RES_BITS_W-1:0] res_bits_o,
  output logic adc_start_o,
  output logic adc_busy_o,
  output logic [SLOT_W-1:0] active_slot_o,
  output logic time_tick_o,
  output logic [RESULT_W-1:0] current_slot_result_o,
  output logic [RESULT_W-1:0] internal_temp_result_o,
  output logic [RESULT_W-1:0] external_temp_result_o,
  output logic [RESULT_W-1:0] pack_voltage_result_o,
  output logic [RESULT_W-1:0] upper_cell_result_o,
  output logic [RESULT_W-1:0] lower_cell_result_o,
  output logic [RESULT_W-1:0] zero_error_result_o,
  output logic [RESULT_W-1:0] spare_slot_result_o,
  output logic [ACC_W-1:0] charge_accumulator_o,
  output logic [ACC_W-1:0] discharge_accumulator_o,
  output logic [ACC_W-1:0] charge_time_counter_o,
  output logic [ACC_W-1:0] discharge_time_counter_o
);

  // Slot controls gathered into one indexable array
  logic [CTRL_W-1:0] ctrl_w [NUM_SLOTS];
  // Result store, one word per slot
  logic [RESULT_W-1:0] res_q [NUM_SLOTS];

  // Time base tick divider
  logic [TICK_W-1:0] tick_cnt_q;
  logic [TICK_W-1:0] tick_cnt_d;
  logic tick_w;
  // Accumulation period counter in time base ticks
  logic [ACC_CNT_W-1:0] acc_cnt_q;
  logic [ACC_CNT_W-1:0] acc_cnt_d;
  logic acc_due_w;

  // Sequencer state and visited slot
  acs_state_t state_q;
  acs_state_t state_d;
  logic [SLOT_W-1:0] slot_q;
  logic [SLOT_W-1:0] slot_d;
  // Conversion length counter, in time base ticks
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [CONV_CNT_W-1:0] conv_cnt_d;

  // Latched settings that drive the analog front end
  logic [2:0] sel_q;
  logic short_q;
  logic ref_q;
  logic [RES_BITS_W-1:0] bits_q;
  logic start_q;

  // Accumulators and time counters
  logic [ACC_W-1:0] chg_acc_q;
  logic [ACC_W-1:0] dis_acc_q;
  logic [ACC_W-1:0] chg_time_q;
  logic [ACC_W-1:0] dis_time_q;

  // Fields of the visited slot's control word
  logic [CTRL_W-1:0] cur_ctrl_w;
  logic slot_en_w;
  logic [2:0] res_code_w;
  logic range_w;
  logic [2:0] sel_w;
  logic [RES_BITS_W-1:0] bits_w;
  logic [CONV_CNT_W-1:0] conv_len_w;
  logic short_w;
  logic conv_done_w;
  logic take_slot_w;
  logic skip_slot_w;
  logic [SLOT_W-1:0] next_slot_w;
  logic [RESULT_W-1:0] new_result_w;
  logic [MAG_W-1:0] acc_mag_w;
  logic acc_sign_w;
  logic acc_step_w;

  // Control ports in slot order
  assign ctrl_w[0] = current_slot_control_i;
  assign ctrl_w[1] = internal_temp_slot_control_i;
  assign ctrl_w[2] = external_temp_slot_control_i;
  assign ctrl_w[3] = pack_voltage_slot_control_i;
  assign ctrl_w[4] = upper_cell_slot_control_i;
  assign ctrl_w[5] = lower_cell_slot_control_i;
  assign ctrl_w[6] = zero_error_slot_control_i;
  assign ctrl_w[7] = spare_slot_control_i;

  // Field decode of the visited slot
  assign cur_ctrl_w = ctrl_w[slot_q];
  assign slot_en_w = cur_ctrl_w[CTRL_EN_BIT];
  assign res_code_w = cur_ctrl_w[CTRL_RES_HI:CTRL_RES_LO];
  assign range_w = cur_ctrl_w[CTRL_REF_BIT];
  assign sel_w = cur_ctrl_w[CTRL_SEL_HI:CTRL_SEL_LO];
  // Code 0 gives 9 bits, code 7 gives 16 bits
  assign bits_w = RES_BASE_BITS + {2'b00, res_code_w};
  // Length is the unit tick count shifted by the resolution
  assign conv_len_w = CONV_CNT_W'(UNIT_TICKS) << bits_w;
  // Offset code, or the dedicated slot, shorts the input internally
  assign short_w = (sel_w == SEL_ZERO_ERROR) ||
                   (slot_q == ZERO_ERROR_SLOT);

  // Slot sequencing decisions
  assign take_slot_w = (state_q == ACS_SETUP) && adc_enable_i &&
                       slot_en_w;
  assign skip_slot_w = (state_q == ACS_SETUP) && adc_enable_i &&
                       !slot_en_w;
  // One extra tick edge so the first partial tick never shortens it
  assign conv_done_w = (state_q == ACS_CONV) && adc_enable_i && tick_w &&
                       (conv_cnt_q == '0);
  // Slot seven wraps back to slot zero
  assign next_slot_w = (slot_q == LAST_SLOT) ? FIRST_SLOT :
                       slot_q + 3'h1;
  // Sign in the top bit, magnitude below it
  assign new_result_w = {adc_sign_i, adc_mag_i};

  // Time base tick: 125 MHz divided down to the 131072 Hz rate
  assign tick_w = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
  assign tick_cnt_d = tick_w ? '0 : tick_cnt_q + 16'h0001;
  assign acc_due_w = tick_w &&
                     (acc_cnt_q == ACC_CNT_W'(ACC_TICKS - 1));
  assign acc_cnt_d = acc_due_w ? '0 :
                     (tick_w ? acc_cnt_q + 18'h00001 : acc_cnt_q);

  // Time base counters
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_cnt_q <= '0;
      acc_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      acc_cnt_q <= acc_cnt_d;
    end
  end

  // Next state, slot and conversion counter
  always_comb begin
    state_d = state_q;
    slot_d = slot_q;
    conv_cnt_d = conv_cnt_q;
    case (state_q)
      ACS_IDLE: begin
        // Every cycle starts from slot zero
        slot_d = FIRST_SLOT;
        if (adc_enable_i) begin
          state_d = ACS_SETUP;
        end
      end
      ACS_SETUP: begin
        if (!adc_enable_i) begin
          state_d = ACS_IDLE;
        end else if (slot_en_w) begin
          // Load the length and start converting
          state_d = ACS_CONV;
          conv_cnt_d = conv_len_w;
        end else begin
          // Disabled slot costs one clock and is passed by
          slot_d = next_slot_w;
        end
      end
      ACS_CONV: begin
        if (!adc_enable_i) begin
          // Disabling aborts; the slot keeps its old result
          state_d = ACS_IDLE;
        end else if (conv_done_w) begin
          state_d = ACS_SETUP;
          slot_d = next_slot_w;
        end else if (tick_w) begin
          conv_cnt_d = conv_cnt_q - 20'h00001;
        end
      end
      default: begin
        state_d = ACS_IDLE;
        slot_d = FIRST_SLOT;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ACS_IDLE;
      slot_q <= FIRST_SLOT;
      conv_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // Front-end settings, latched when a slot is taken
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sel_q <= SEL_CURRENT;
      short_q <= 1'b0;
      ref_q <= REF_170MV;
      bits_q <= RES_BASE_BITS;
      start_q <= 1'b0;
    end else begin
      start_q <= take_slot_w;
      if (take_slot_w) begin
        sel_q <= sel_w;
        short_q <= short_w;
        ref_q <= range_w;
        bits_q <= bits_w;
      end
    end
  end

  // Result store: only the finishing slot's word changes, as a whole
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_result
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        res_q[s] <= RESULT_RESET;
      end else if (conv_done_w && (slot_q == SLOT_W'(s))) begin
        res_q[s] <= new_result_w;
      end
    end
  end

  // Accumulation reads the slot zero result only
  assign acc_sign_w = res_q[CURRENT_SLOT][SIGN_BIT];
  assign acc_mag_w = res_q[CURRENT_SLOT][MAG_W-1:0];
  assign acc_step_w = acc_due_w && accum_enable_i;

  // Charge and discharge sums and their time counters
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      chg_acc_q <= ACC_RESET;
      dis_acc_q <= ACC_RESET;
      chg_time_q <= ACC_RESET;
      dis_time_q <= ACC_RESET;
    end else if (acc_step_w) begin
      if (!acc_sign_w) begin
        // Positive reading is charge current
        chg_acc_q <= chg_acc_q + {17'h00000, acc_mag_w};
        chg_time_q <= chg_time_q + 32'h0000_0001;
      end else begin
        // Negative reading is discharge current
        dis_acc_q <= dis_acc_q + {17'h00000, acc_mag_w};
        dis_time_q <= dis_time_q + 32'h0000_0001;
      end
    end
  end

  // Front-end and status outputs
  assign mux_sel_o = sel_q;
  assign mux_short_o = short_q;
  assign ref_range_o = ref_q;
  assign res_bits_o = bits_q;
  assign adc_start_o = start_q;
  assign adc_busy_o = (state_q == ACS_CONV);
  assign active_slot_o = slot_q;
  assign time_tick_o = tick_w;

  // Result outputs straight from the store
  assign current_slot_result_o = res_q[0];
  assign internal_temp_result_o = res_q[1];
  assign external_temp_result_o = res_q[2];
  assign pack_voltage_result_o = res_q[3];
  assign upper_cell_result_o = res_q[4];
  assign lower_cell_result_o = res_q[5];
  assign zero_error_result_o = res_q[6];
  assign spare_slot_result_o = res_q[7];

  // Accumulator outputs
  assign charge_accumulator_o = chg_acc_q;
  assign discharge_accumulator_o = dis_acc_q;
  assign charge_time_counter_o = chg_time_q;
  assign discharge_time_counter_o = dis_time_q;

endmodule

// ---- sim/acs_sequencer_properties.sv ----
// Port-level assertions for the conversion sequencer, bound to its top
module acs_seq_props
  import acs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic adc_enable_i,
  input wire logic [CTRL_W-1:0] current_slot_control_i,
  input wire logic [CTRL_W-1:0] internal_temp_slot_control_i,
  input wire logic [CTRL_W-1:0] external_temp_slot_control_i,
  input wire logic [CTRL_W-1:0] pack_voltage_slot_control_i,
  input wire logic [CTRL_W-1:0] upper_cell_slot_control_i,
  input wire logic [CTRL_W-1:0] lower_cell_slot_control_i,
  input wire logic [CTRL_W-1:0] zero_error_slot_control_i,
  input wire logic [CTRL_W-1:0] spare_slot_control_i,
  input wire logic [2:0] mux_sel_o,
  input wire logic mux_short_o,
  input wire logic ref_range_o,
  input wire logic [RES_BITS_W-1:0] res_bits_o,
  input wire logic adc_start_o,
  input wire logic adc_busy_o,
  input wire logic [SLOT_W-1:0] active_slot_o,
  input wire logic time_tick_o
);
  // All controls packed in slot order, slot 0 lowest
  wire logic [NUM_SLOTS*CTRL_W-1:0] all_cw = {spare_slot_control_i,
    zero_error_slot_control_i, lower_cell_slot_control_i,
    upper_cell_slot_control_i, pack_voltage_slot_control_i,
    external_temp_slot_control_i, internal_temp_slot_control_i,
    current_slot_control_i};
  // Control word of the slot being visited
  wire logic [CTRL_W-1:0] cw = all_cw[active_slot_o*CTRL_W +: CTRL_W];
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_start; $rose(adc_busy_o) |-> adc_start_o && $past(cw[7]);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_res;
    adc_start_o |-> res_bits_o == RES_BASE_BITS + 5'($past(cw[6:4]));
  endproperty
  a_res: assert property (p_res) else $error("bad width");
  property p_ref; adc_start_o |-> ref_range_o == $past(cw[3]); endproperty
  a_ref: assert property (p_ref) else $error("bad range");
  property p_sel; adc_start_o |-> mux_sel_o == $past(cw[2:0]); endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_short; adc_start_o |-> mux_short_o ==
    (mux_sel_o == SEL_ZERO_ERROR || active_slot_o == ZERO_ERROR_SLOT);
  endproperty
  a_short: assert property (p_short) else $error("bad short");
  // A disabled slot costs one cycle and the index wraps after slot 7
  property p_skip;
    adc_enable_i && $past(adc_enable_i) && !$past(reset_i) && !adc_busy_o
      && !cw[7] ##1 adc_enable_i |-> active_slot_o == $past(active_slot_o)
      + 3'h1;
  endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  // Even the shortest conversion runs far beyond eight cycles
  property p_long;
    $fell(adc_busy_o) && $past(adc_enable_i) |-> $past(adc_busy_o, 8);
  endproperty
  a_long: assert property (p_long) else $error("too short");
  // Clocks since the last time base tick, for the tick spacing check
  logic [15:0] gap_q;
  always_ff @(posedge clock_i) begin
    if (reset_i || time_tick_o) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  property p_tick; time_tick_o == (gap_q == 16'(TICK_CYCLES - 1));
  endproperty
  a_tick: assert property (p_tick) else $error("bad tick");
endmodule

bind acs_sequencer acs_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clock_i, .reset_i, .adc_enable_i, .current_slot_control_i,
  .internal_temp_slot_control_i, .external_temp_slot_control_i,
  .pack_voltage_slot_control_i, .upper_cell_slot_control_i,
  .lower_cell_slot_control_i, .zero_error_slot_control_i,
  .spare_slot_control_i, .mux_sel_o, .mux_short_o, .ref_range_o,
  .res_bits_o, .adc_start_o, .adc_busy_o, .active_slot_o, .time_tick_o
);

// ---- sim/acs_adc_model.sv ----
// Behavioural analog mux and converter facing the sequencer
module acs_adc_model
  import acs_pkg::*;
(
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic busy_i,
  input wire logic short_i,
  output logic sign_o,
  output logic [MAG_W-1:0] mag_o,
  output logic [RESULT_W-1:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32998; // Fixed seed, readings repeat run to run
  logic sign_q = 1'b0; // Alternates so both polarities occur
  logic flip_q = 1'b0; // Toggles every cycle
  logic [RESULT_W-1:0] word_q = '0; // Reading of the current conversion
  assign word_o = word_q;
  // New reading per conversion; a shorted input reads a small offset
  always @(posedge clock_i) begin
    flip_q <= ~flip_q;
    if (start_i) begin
      word_q <= short_i ? {sign_q, 13'h0, 2'($random(seed))}
        : {sign_q, 15'($random(seed))};
      sign_q <= ~sign_q;
    end
  end
  // Outside a conversion the output is stale, so it keeps changing
  assign {sign_o, mag_o} = (busy_i || !flip_q) ? word_q : ~word_q;
endmodule

// ---- sim/adc_conversion_sequencer_bench.sv ----
// Self-checking bench for the conversion sequencer
module adc_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  localparam int TC = 4; // Shortened time base tick
  localparam int AT = 8; // Shortened accumulation period, in ticks
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic adc_enable_i = 1'b0;
  logic accum_enable_i = 1'b0;
  logic adc_sign_i, mux_short_o, ref_range_o, adc_start_o, adc_busy_o;
  logic busy_q;
  logic sh; // Expected short for the slot just taken
  logic acc_seen; // Accumulation enable as the design sampled it
  logic [MAG_W-1:0] adc_mag_i;
  logic [2:0] mux_sel_o;
  logic [RES_BITS_W-1:0] res_bits_o;
  logic [SLOT_W-1:0] active_slot_o;
  logic [CTRL_W-1:0] ctrl [NUM_SLOTS]; // Slot controls in slot order
  logic [RESULT_W-1:0] res [NUM_SLOTS]; // Results in slot order
  logic [RESULT_W-1:0] snap [NUM_SLOTS]; // Results expected to stand
  logic [RESULT_W-1:0] word, res0_q; // Model reading, old slot 0 result
  logic [ACC_W-1:0] ca, da, ct, dt;
  logic [ACC_W-1:0] e_ca = '0, e_da = '0, e_ct = '0, e_dt = '0;
  integer seed = 32998;
  integer n_errors = 0;
  integer check_count = 0;
  integer nxt = 0, cur = 0, len = 0, lim = 0, n_conv = 0, now = 0, last = 0;

  acs_sequencer #(.TICK_CYCLES(TC), .ACC_TICKS(AT)) uut (
    .clock_i, .reset_i, .adc_enable_i, .accum_enable_i,
    .current_slot_control_i(ctrl[0]), .internal_temp_slot_control_i(ctrl[1]),
    .external_temp_slot_control_i(ctrl[2]),
    .pack_voltage_slot_control_i(ctrl[3]),
    .upper_cell_slot_control_i(ctrl[4]), .lower_cell_slot_control_i(ctrl[5]),
    .zero_error_slot_control_i(ctrl[6]), .spare_slot_control_i(ctrl[7]),
    .adc_sign_i, .adc_mag_i, .mux_sel_o, .mux_short_o, .ref_range_o,
    .res_bits_o, .adc_start_o, .adc_busy_o, .active_slot_o, .time_tick_o(),
    .current_slot_result_o(res[0]), .internal_temp_result_o(res[1]),
    .external_temp_result_o(res[2]), .pack_voltage_result_o(res[3]),
    .upper_cell_result_o(res[4]), .lower_cell_result_o(res[5]),
    .zero_error_result_o(res[6]), .spare_slot_result_o(res[7]),
    .charge_accumulator_o(ca), .discharge_accumulator_o(da),
    .charge_time_counter_o(ct), .discharge_time_counter_o(dt)
  );
  acs_adc_model model (.clock_i, .start_i(adc_start_o), .busy_i(adc_busy_o),
    .short_i(mux_short_o), .sign_o(adc_sign_i), .mag_o(adc_mag_i),
    .word_o(word));

  always #4 clock_i = ~clock_i;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // First enabled slot at or after a given one, wrapping
  function automatic integer next_slot(input integer from);
    for (int i = 0; i < NUM_SLOTS; i++)
      if (ctrl[(from + i) % NUM_SLOTS][7]) return (from + i) % NUM_SLOTS;
    return 0;
  endfunction

  // Bounded wait for a number of completed conversions
  task automatic wait_conv(input integer n);
    integer target;
    target = n_conv + n;
    for (int k = 0; k < 20000 * n && n_conv < target; k++) begin
      @(negedge clock_i);
    end
    check("wait", n_conv >= target, 1'b1);
  endtask

  // Enable as seen at the edge that may step the accumulators
  always @(posedge clock_i) acc_seen <= accum_enable_i;

  // Reference model, sampled where outputs have settled
  always @(negedge clock_i) begin
    if (!reset_i) begin
      now++;
      if (!adc_enable_i) nxt = 0;
      if (adc_start_o) begin
        cur = next_slot(nxt);
        lim = (4 << (9 + ctrl[cur][6:4])) * TC;
        len = 0;
        snap = res;
        check("slot", active_slot_o, cur);
        check("select", mux_sel_o, ctrl[cur][2:0]);
        check("range", ref_range_o, ctrl[cur][3]);
        check("bits", res_bits_o, 9 + ctrl[cur][6:4]);
        sh = ctrl[cur][2:0] == SEL_ZERO_ERROR || cur == ZERO_ERROR_SLOT;
        check("short", mux_short_o, sh);
      end
      len += adc_busy_o;
      if (busy_q && !adc_busy_o) begin
        if (adc_enable_i) begin
          snap[cur] = word;
          n_conv++;
          nxt = (cur + 1) % NUM_SLOTS;
          check("time", len >= lim && len <= lim + TC + 1, 1'b1);
        end
        foreach (res[i])
          check("result", res[i], snap[i]);
      end
      if (ct !== e_ct || dt !== e_dt) begin
        check("gate", acc_seen, 1'b1);
        if (last > 0) check("period", now - last, AT * TC);
        last = accum_enable_i ? now : 0;
        if (res0_q[15]) e_da += res0_q[14:0];
        else e_ca += res0_q[14:0];
        if (res0_q[15]) e_dt++;
        else e_ct++;
        check("charge", ca, e_ca);
        check("discharge", da, e_da);
        check("charge time", ct, e_ct);
        check("discharge time", dt, e_dt);
      end
      if (last > 0 && now - last > AT * TC) begin
        check("late", now - last, AT * TC);
        last = 0;
      end
      if (!accum_enable_i) last = 0;
      res0_q = res[0];
      busy_q = adc_busy_o;
    end
  end

  // Main sequence: idle loop, host setup, abort, then random controls
  initial begin
    for (int i = 0; i < NUM_SLOTS; i++) ctrl[i] = 8'h00;
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    adc_enable_i = 1'b1;
    accum_enable_i = 1'b1;
    repeat (24) @(negedge clock_i);
    check("idle busy", adc_busy_o, 1'b0);
    adc_enable_i = 1'b0;
    @(negedge clock_i);
    ctrl[0] = 8'h80;
    ctrl[1] = 8'h89;
    ctrl[3] = 8'h9B;
    ctrl[6] = 8'h8C;
    adc_enable_i = 1'b1;
    wait_conv(1);
    accum_enable_i = 1'b0;
    wait_conv(1);
    accum_enable_i = 1'b1;
    wait_conv(2);
    while (!adc_start_o) @(negedge clock_i);
    repeat (40) @(negedge clock_i);
    adc_enable_i = 1'b0;
    repeat (4) @(negedge clock_i);
    for (int i = 0; i < NUM_SLOTS; i++) ctrl[i] = 8'($random(seed)) & 8'h8F;
    ctrl[7][7] = 1'b1;
    ctrl[0][7] = 1'b1; // Slot 0 runs first, its reading negative
    adc_enable_i = 1'b1;
    wait_conv(2);
    check("both signs", e_ct > 0 && e_dt > 0, 1'b1);
    check("conversions", n_conv, 6);
    complete_run();
  end

  // Watchdog: the run needs about 60k cycles
  initial begin
    #720000;
    n_errors++;
    complete_run();
  end
endmodule
